//--- dpps_power_state.sv
`timescale 1ns/100ps
`default_nettype none

module dpps_power_state #(
    parameter int unsigned LONG_CYC   = dpps_pkg::LONG_PRESS_CYC,
    parameter int unsigned DEB_CYC    = dpps_pkg::DEBOUNCE_CYC,
    parameter int unsigned BLINK_CYC  = dpps_pkg::BLINK_PERIOD_CYC,
    parameter int unsigned FLASH_CYC  = dpps_pkg::BLINK_ON_CYC,
    parameter int unsigned PMIN_CYC   = dpps_pkg::PULSE_MIN_CYC,
    parameter int unsigned PGAP_CYC   = dpps_pkg::PULSE_GAP_CYC,
    parameter int unsigned CNT_W      = dpps_pkg::CNT_W
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic power_button,
    input  wire logic pulse_in,
    input  wire logic fault_detected,
    output logic      green_led,
    output logic      display_en,
    output logic      fault_display_en,
    output logic      settings_en,
    output logic      fill_en,
    output logic      fault_relay,
    output logic      dose_permit,
    output logic      pulse_count,
    output logic [1:0] status
);

    dpps_pkg::dpps_status_t state_q;
    dpps_pkg::dpps_status_t state_d;
    logic [CNT_W-1:0]       blink_cnt_q;
    logic [CNT_W-1:0]       plen_cnt_q;
    logic [CNT_W-1:0]       pgap_cnt_q;
    logic                   pulse_q;
    logic                   short_press;
    logic                   long_press;

    dpps_button #(
        .CNT_W    (CNT_W),
        .DEB_CYC  (DEB_CYC),
        .LONG_CYC (LONG_CYC)
    ) u_button (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .clk_en      (clk_en),
        .button_raw  (power_button),
        .short_press (short_press),
        .long_press  (long_press)
    );

    // state transitions; short press in off is ignored
    always_comb begin
        state_d = state_q;
        case (state_q)
            dpps_pkg::DPPS_OFF:
                if (long_press)
                    state_d = dpps_pkg::DPPS_STANDBY;
            dpps_pkg::DPPS_STANDBY:
                if (long_press)
                    state_d = dpps_pkg::DPPS_OFF;
                else if (short_press)
                    state_d = dpps_pkg::DPPS_ON;
            dpps_pkg::DPPS_ON:
                if (long_press)
                    state_d = dpps_pkg::DPPS_OFF;
                else if (short_press)
                    state_d = dpps_pkg::DPPS_STANDBY;
            default:
                state_d = dpps_pkg::DPPS_OFF;
        endcase
    end

    wire is_off     = (state_d == dpps_pkg::DPPS_OFF);
    wire is_on      = (state_d == dpps_pkg::DPPS_ON);
    wire blink_wrap = (blink_cnt_q >= CNT_W'(BLINK_CYC - 1));
    wire flash_on   = (blink_cnt_q < CNT_W'(FLASH_CYC));
    // a pulse counts on its falling edge only if it stood long enough and the
    // previous counted pulse is at least one period back
    wire pulse_fall = pulse_q && !pulse_in;
    wire plen_ok    = (plen_cnt_q >= CNT_W'(PMIN_CYC - 1));
    wire pgap_ok    = (pgap_cnt_q >= CNT_W'(PGAP_CYC - 1));
    wire pulse_take = pulse_fall && plen_ok && pgap_ok;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q          <= dpps_pkg::DPPS_OFF;
            blink_cnt_q      <= '0;
            plen_cnt_q       <= '0;
            pgap_cnt_q       <= '0;
            pulse_q          <= 1'b0;
            green_led        <= 1'b0;
            display_en       <= 1'b0;
            fault_display_en <= 1'b0;
            settings_en      <= 1'b0;
            fill_en          <= 1'b0;
            fault_relay      <= 1'b0;
            dose_permit      <= 1'b0;
            pulse_count      <= 1'b0;
            status           <= 2'h0;
        end else if (clk_en) begin
            state_q     <= state_d;
            status      <= state_d;
            blink_cnt_q <= blink_wrap ? '0 : blink_cnt_q + 1'b1;
            // steady in on, brief flash in off and standby
            green_led   <= is_on ? 1'b1 : flash_on;
            display_en  <= !is_off;
            settings_en <= !is_off;
            fill_en     <= !is_off;
            fault_display_en <= is_on;
            // fail-safe: drops out on a fault, never held outside on
            fault_relay <= is_on && !fault_detected;
            dose_permit <= is_on;
            pulse_q     <= pulse_in;
            plen_cnt_q  <= (pulse_in && !plen_ok) ? plen_cnt_q + 1'b1 :
                           (pulse_in ? plen_cnt_q : '0);
            pgap_cnt_q  <= pulse_take ? '0 :
                           (pgap_ok ? pgap_cnt_q : pgap_cnt_q + 1'b1);
            pulse_count <= pulse_take && is_on;
        end else begin
            pulse_count <= 1'b0;
        end
    end

    a_dose_only_on: assert property (@(posedge core_clk) disable iff (!rst_n)
        dose_permit |-> status == 2'(dpps_pkg::DPPS_ON))
        else $error("dosing permitted outside on");

    a_relay_off_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        status != 2'(dpps_pkg::DPPS_ON) |-> !fault_relay && !fault_display_en)
        else $error("relay or fault display active outside on");

    a_off_dark: assert property (@(posedge core_clk) disable iff (!rst_n)
        status == 2'(dpps_pkg::DPPS_OFF) |-> !display_en && !dose_permit)
        else $error("display or dosing active in off");

    a_on_led_lit: assert property (@(posedge core_clk) disable iff (!rst_n)
        status == 2'(dpps_pkg::DPPS_ON) |-> green_led)
        else $error("led not lit in on");

    a_long_to_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && long_press && state_q != dpps_pkg::DPPS_OFF
        |=> status == 2'(dpps_pkg::DPPS_OFF))
        else $error("long press did not switch off");

    a_long_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && long_press && state_q == dpps_pkg::DPPS_OFF
        |=> status == 2'(dpps_pkg::DPPS_STANDBY))
        else $error("long press did not enter standby");

    a_short_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && short_press && state_q == dpps_pkg::DPPS_STANDBY
        |=> status == 2'(dpps_pkg::DPPS_ON))
        else $error("short press did not enter on");

    a_short_back: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && short_press && state_q == dpps_pkg::DPPS_ON
        |=> status == 2'(dpps_pkg::DPPS_STANDBY))
        else $error("short press did not return to standby");

    a_relay_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && fault_detected |=> !fault_relay)
        else $error("relay held during fault");

    // the spare status code must never be reached, not even after a glitch-free reset
    a_status_legal: assert property (@(posedge core_clk) disable iff (!rst_n)
        status == 2'(dpps_pkg::DPPS_OFF) || status == 2'(dpps_pkg::DPPS_STANDBY) ||
        status == 2'(dpps_pkg::DPPS_ON))
        else $error("status holds an unused code");

    a_standby_panel: assert property (@(posedge core_clk) disable iff (!rst_n)
        status == 2'(dpps_pkg::DPPS_STANDBY) |-> display_en && settings_en && fill_en)
        else $error("panel not usable in standby");

    a_on_faults_shown: assert property (@(posedge core_clk) disable iff (!rst_n)
        status == 2'(dpps_pkg::DPPS_ON) |-> fault_display_en && display_en)
        else $error("faults not shown in on");

    a_pulse_only_on: assert property (@(posedge core_clk) disable iff (!rst_n)
        pulse_count |-> status == 2'(dpps_pkg::DPPS_ON))
        else $error("pulse counted outside on");

    // a frozen block must not move; a stuck enable would otherwise look like a dead button
    a_freeze_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        rst_n && !clk_en |=> $stable(status) && $stable(green_led))
        else $error("state moved while clock enable low");

endmodule : dpps_power_state

`default_nettype wire

//--- dpps_pkg.sv
package dpps_pkg;

    typedef enum logic [1:0] {
        DPPS_OFF,
        DPPS_STANDBY,
        DPPS_ON
    } dpps_status_t;

    // clock rate
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 40;

    // power button timing
    localparam int unsigned LONG_PRESS_MS   = 2000;
    localparam int unsigned DEBOUNCE_MS     = 20;
    localparam int unsigned LONG_PRESS_CYC  = LONG_PRESS_MS * (CLK_HZ / 1000);
    localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1000);

    // green led flash pattern in off and standby
    localparam int unsigned BLINK_PERIOD_MS = 2000;
    localparam int unsigned BLINK_ON_MS     = 100;
    localparam int unsigned BLINK_PERIOD_CYC = BLINK_PERIOD_MS * (CLK_HZ / 1000);
    localparam int unsigned BLINK_ON_CYC    = BLINK_ON_MS * (CLK_HZ / 1000);

    // pulse input limits
    localparam int unsigned PULSE_MIN_MS    = 50;
    localparam int unsigned PULSE_MAX_HZ    = 10;
    localparam int unsigned PULSE_MIN_CYC   = PULSE_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned PULSE_GAP_CYC   = CLK_HZ / PULSE_MAX_HZ;

    localparam int unsigned CNT_W           = 26;

endpackage : dpps_pkg

//--- dpps_button.sv
`timescale 1ns/100ps
`default_nettype none

// debounces the power button and reports one event per press, or both if the release settles in the cycle the long threshold is reached
module dpps_button #(
    parameter int unsigned CNT_W     = dpps_pkg::CNT_W,
    parameter int unsigned DEB_CYC   = dpps_pkg::DEBOUNCE_CYC,
    parameter int unsigned LONG_CYC  = dpps_pkg::LONG_PRESS_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic button_raw,
    output logic      short_press,
    output logic      long_press
);

    logic             level_q;
    logic [CNT_W-1:0] deb_cnt_q;
    logic [CNT_W-1:0] hold_cnt_q;
    logic             fired_q;
    wire              differs   = (button_raw != level_q);
    wire              deb_done  = (deb_cnt_q >= CNT_W'(DEB_CYC - 1));
    wire              hold_done = (hold_cnt_q >= CNT_W'(LONG_CYC - 1));
    wire              releasing = differs && deb_done && level_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            level_q     <= 1'b0;
            deb_cnt_q   <= '0;
            hold_cnt_q  <= '0;
            fired_q     <= 1'b0;
            short_press <= 1'b0;
            long_press  <= 1'b0;
        end else if (clk_en) begin
            // a level must stay changed for the whole debounce span
            deb_cnt_q   <= (differs && !deb_done) ? deb_cnt_q + 1'b1 : '0;
            if (differs && deb_done)
                level_q <= button_raw;
            if (level_q && !hold_done)
                hold_cnt_q <= hold_cnt_q + 1'b1;
            else if (!level_q)
                hold_cnt_q <= '0;
            // long fires at the threshold while held; short only on an early release
            long_press  <= level_q && hold_done && !fired_q;
            short_press <= releasing && !fired_q;
            if (level_q && hold_done)
                fired_q <= 1'b1;
            else if (!level_q)
                fired_q <= 1'b0;
        end else begin
            short_press <= 1'b0;
            long_press  <= 1'b0;
        end
    end

    a_one_event: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(short_press && long_press))
        else $error("short and long press together");

endmodule : dpps_button

`default_nettype wire

//--- dpps_operator.sv
`timescale 1ns/100ps
`default_nettype none
// stands in for the person at the power button and the external pulse contact
module dpps_operator (
    input  wire logic core_clk,
    output var logic  power_button,
    output var logic  pulse_in
);
    initial
    begin
        power_button = 1'b0;
        pulse_in     = 1'b0;
    end

    task automatic press(input int hold);
        @(posedge core_clk) power_button <= 1'b1;
        repeat (hold) @(posedge core_clk);
        power_button <= 1'b0;
    endtask : press

    // width and spacing are the caller's, so the bench can also break them on purpose
    task automatic pulse(input int high, input int low);
        @(posedge core_clk) pulse_in <= 1'b1;
        repeat (high) @(posedge core_clk);
        pulse_in <= 1'b0;
        repeat (low) @(posedge core_clk);
    endtask : pulse
endmodule : dpps_operator
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic       core_clk;
    logic       rst_n;
    logic       clk_en;
    logic       fault_detected;
    wire logic  power_button;
    wire logic  pulse_in;
    logic       green_led;
    logic       display_en;
    logic       fault_display_en;
    logic       settings_en;
    logic       fill_en;
    logic       fault_relay;
    logic       dose_permit;
    logic       pulse_count;
    logic [1:0] status;
    int         fails;
    int         total_checks;
    int         pulse_n;
    int         n;
    // outputs packed as status, display, fault display, settings, fill, relay, dose
    localparam logic [7:0] EXP_OFF = {dpps_pkg::DPPS_OFF, 6'h00};
    localparam logic [7:0] EXP_SB  = {dpps_pkg::DPPS_STANDBY, 6'h2c};
    localparam logic [7:0] EXP_ON  = {dpps_pkg::DPPS_ON, 6'h3f};
    // short spans keep the run brief; of the ratios between the timings only pulse width to gap is kept
    localparam int unsigned T_LONG  = 20;
    localparam int unsigned T_DEB   = 4;
    localparam int unsigned T_BLINK = 40;
    localparam int unsigned T_FLASH = 5;
    localparam int unsigned T_PMIN  = 8;
    localparam int unsigned T_PGAP  = 16;

    dpps_operator dpps_operator_i (
        .core_clk     (core_clk),
        .power_button (power_button),
        .pulse_in     (pulse_in)
    );
    dpps_power_state #(.LONG_CYC(T_LONG), .DEB_CYC(T_DEB), .BLINK_CYC(T_BLINK),
        .FLASH_CYC(T_FLASH), .PMIN_CYC(T_PMIN), .PGAP_CYC(T_PGAP)) dpps_power_state_i (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .power_button(power_button),
        .pulse_in(pulse_in), .fault_detected(fault_detected), .green_led(green_led),
        .display_en(display_en), .fault_display_en(fault_display_en),
        .settings_en(settings_en), .fill_en(fill_en), .fault_relay(fault_relay),
        .dose_permit(dose_permit), .pulse_count(pulse_count), .status(status)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
        if (pulse_count === 1'b1)
            pulse_n <= pulse_n + 1;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask : tick

    function automatic logic [7:0] outs();
        return {status, display_en, fault_display_en, settings_en, fill_en, fault_relay,
                dose_permit};
    endfunction : outs

    // lit cycles over one flash period; the counter runs free so any window works
    task automatic led_lit(output int c);
        c = 0;
        repeat (40)
        begin
            tick(1);
            if (green_led === 1'b1)
                c++;
        end
    endtask : led_lit

    // bounded wait for a status change after a press
    task automatic go(input int hold, input logic [1:0] exp);
        int k;
        k = 0;
        dpps_operator_i.press(hold);
        tick(1);
        while (status !== exp && k < 60)
        begin
            tick(1);
            k++;
        end
        chk(status, exp);
        if (status !== exp)
            end_of_test();
        tick(12);
    endtask : go

    task automatic t_off();
        chk(outs(), EXP_OFF);
        led_lit(n);
        chk(n, 5);
        go(8, dpps_pkg::DPPS_OFF);
        chk(outs(), EXP_OFF);
        $display("test off done");
    endtask : t_off

    task automatic t_standby();
        int p0;
        go(30, dpps_pkg::DPPS_STANDBY);
        chk(outs(), EXP_SB);
        led_lit(n);
        chk(n, 5);
        p0 = pulse_n;
        dpps_operator_i.pulse(10, 20);
        chk(pulse_n - p0, 0);
        $display("test standby done");
    endtask : t_standby

    task automatic t_on();
        go(8, dpps_pkg::DPPS_ON);
        chk(outs(), EXP_ON);
        led_lit(n);
        chk(n, 40);
        @(posedge core_clk) fault_detected <= 1'b1;
        tick(4);
        chk(fault_relay, 1'b0);
        @(posedge core_clk) fault_detected <= 1'b0;
        tick(4);
        chk(fault_relay, 1'b1);
        $display("test on done");
    endtask : t_on

    // a good pulse, a too short one, then two closer together than the rate allows
    task automatic t_pulse();
        int p0;
        p0 = pulse_n;
        dpps_operator_i.pulse(10, 20);
        chk(pulse_n - p0, 1);
        dpps_operator_i.pulse(3, 20);
        chk(pulse_n - p0, 1);
        dpps_operator_i.pulse(10, 2);
        dpps_operator_i.pulse(10, 20);
        chk(pulse_n - p0, 2);
        $display("test pulse done");
    endtask : t_pulse

    // with the enable low the block ignores a long press and holds every output except pulse_count, which drops low
    task automatic t_freeze();
        logic v;
        int   k;
        @(posedge core_clk) clk_en <= 1'b0;
        tick(1);
        v = green_led;
        k = 0;
        repeat (40)
        begin
            tick(1);
            if (green_led !== v)
                k++;
        end
        chk(k, 0);
        dpps_operator_i.press(30);
        tick(12);
        chk(outs(), EXP_OFF);
        @(posedge core_clk) clk_en <= 1'b1;
        tick(12);
        chk(outs(), EXP_OFF);
        $display("test freeze done");
    endtask : t_freeze

    task automatic t_back();
        go(8, dpps_pkg::DPPS_STANDBY);
        go(30, dpps_pkg::DPPS_OFF);
        chk(outs(), EXP_OFF);
        go(30, dpps_pkg::DPPS_STANDBY);
        go(8, dpps_pkg::DPPS_ON);
        go(30, dpps_pkg::DPPS_OFF);
        $display("test back done");
    endtask : t_back

    initial
    begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        fault_detected = 1'b0;
        fails = 0;
        total_checks = 0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        tick(2);
        t_off();
        t_standby();
        t_on();
        t_pulse();
        t_back();
        t_freeze();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
